// *** inc/port_data_pkg.sv ***
// package: register map, field layout and carrier types of the port data block
// assumes: one clock domain; pins arrive unsynchronised and are synchronised inside
package port_data_pkg;
  // register address = {port index, register kind}
  localparam int ADDR_W = 5;
  localparam logic [1:0] PORT_A = 2'h0;
  localparam logic [1:0] PORT_B = 2'h1;
  localparam logic [1:0] PORT_C = 2'h2;
  localparam logic [1:0] PORT_D = 2'h3;
  localparam logic [2:0] REG_PIN_INPUT_LEVELS = 3'h0;
  localparam logic [2:0] REG_PIN_OUTPUT_LATCH = 3'h1;
  localparam logic [2:0] REG_DIRECTION = 3'h2;
  localparam logic [2:0] REG_DRIVE_SELECT = 3'h3;
  localparam logic [2:0] REG_OUTPUT_CELL_ACCESS = 3'h4;
  localparam logic [2:0] REG_OUTPUT_CELL_LOAD_BLOCK = 3'h5;
  localparam logic [2:0] REG_INPUT_CELL_READBACK = 3'h6;
  localparam logic [2:0] REG_DRIVER_ENABLE_STATUS = 3'h7;
  // reset values
  localparam logic [7:0] RST_OUTPUT_LATCH = 8'h00;
  localparam logic [7:0] RST_LOAD_BLOCK = 8'h00;
  localparam logic [7:0] RST_DIRECTION = 8'h00;
  localparam logic [7:0] RST_DRIVE = 8'h00;
  localparam logic [7:0] RST_CELL = 8'h00;
  // drive select layout per port, and the port d pin mask
  localparam logic [7:0] DRV_SLEW_MASK_AB = 8'h0f;
  localparam logic [7:0] DRV_OPEN_DRAIN_MASK_AB = 8'hf0;
  localparam logic [7:0] DRV_OPEN_DRAIN_MASK_C = 8'hff;
  localparam logic [7:0] DRV_SLEW_MASK_D = 8'h07;
  localparam logic [7:0] PORT_D_MASK = 8'h07;
  // port d pin positions and the port c byte-lane pin
  localparam int PD_STROBE = 0;
  localparam int PD_CLOCK = 1;
  localparam int PD_CHIP_SEL = 2;
  localparam int PC_BYTE_LANE = 7;

  typedef struct packed {
    logic [2:0] d;
    logic [7:0] c;
    logic [7:0] b;
    logic [7:0] a;
  } pin_bus_s;

  typedef struct packed {
    logic sel;
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [7:0] wdata;
  } reg_req_s;
endpackage

// *** rtl/port_data_register_logic.sv ***
// port data register logic: four ports, macrocells, driver control and readback
// assumes: clk_sys is the shared clock input feeding the macrocells; product terms
// and macrocell next values come from logic on the same clock; pins are asynchronous
//
// Operation
// R1 - pin driven with data-out bit when direction bit or output-enable term is 1
// R2 - data-out register reads back the written value, not the pin
// R3 - output macrocell write loads unmasked flip-flops; read returns macrocell outputs
// R4 - mask bit 1 blocks processor loading; masks reset to 0
// R5 - macrocell, mask, input cell and enable status registers exist on ports a-c only
// R6 - input macrocells store pin inputs, feed logic bus, readable by processor
// R7 - enable status reads 1 for driving pins, 0 for tri-stated pins; code reads the enable before open-drain release, so a released pin reads 1
// R8 - first macrocell group goes to port a or b, second to b or c
// R9 - ports a,b: low nibble fast slew, high nibble open drain
// R10 - only port a can be the data bus or peripheral buffer
// R11 - port c has no address-out control; all pins open-drain capable
// R12 - top pin of port c can serve as byte-lane enable input
// R13 - port d has three pins, no control, inputs go direct to logic
// R14 - chip-select input high disables flash, sram and register space select
// R15 - three external chip selects, one product term each, polarity configurable
// R16 - chip-select pin driver enabled by its output-enable term or direction bit
// R17 - shared clock input clocks macrocells and power-down counter; code has no power-down counter
// R18 - direction 1 is output, 0 input; all reset to input
// R19 - data-in read returns current pin levels
// R20 - data-out register resets to zero
`timescale 1ns/1ps
module port_data_register_logic
  import port_data_pkg::*;
(
  input wire logic clk_sys, // shared clock input
  input wire logic reset, // synchronous, active high
  input port_data_pkg::reg_req_s regReq, // processor register request
  output logic [7:0] regRdata, // read data, one cycle after rd
  input port_data_pkg::pin_bus_s pinIn, // pin levels, asynchronous
  output port_data_pkg::pin_bus_s pinOut, // pin output level
  output port_data_pkg::pin_bus_s pinOe, // pin driver enable, high drives
  output port_data_pkg::pin_bus_s slewFast, // fast slew select per pin
  input port_data_pkg::pin_bus_s oeTerm, // output-enable product terms
  input port_data_pkg::pin_bus_s pldPinSel, // pin shows macrocell instead of latch
  input wire logic [7:0] groupAbNext, // array value for macrocell_group_ab
  input wire logic [7:0] groupBcNext, // array value for macrocell_group_bc
  input wire logic groupAbToB, // 1 routes group ab to port b, else a
  input wire logic groupBcToC, // 1 routes group bc to port c, else b
  input wire logic [2:0] imcCapture, // per port a-c: input macrocells store pins
  output logic [23:0] pldInputBus, // input macrocell outputs, ports c,b,a
  output logic [2:0] portDDirect, // port d pins straight to the array
  input wire logic dataPortMode, // port a is the processor data bus
  input wire logic periphMode, // port a is the peripheral buffer
  input wire logic [7:0] mcuDataOut, // processor data for port a bus modes
  input wire logic mcuDataOe, // processor drives port a in bus modes
  input wire logic byteLaneMode, // port c top pin is byte_lane_enable
  output logic byteLaneEnable, // synchronised byte_lane_enable input
  input wire logic [2:0] ecsTerm, // external chip select product terms
  input wire logic [2:0] ecsActiveLow, // polarity per external chip select
  input wire logic [2:0] ecsPinSel, // port d pin carries its chip select
  output logic [2:0] externalChipSelect, // formed chip selects
  output logic memEnable, // flash, sram and register space allowed
  output logic addrLatchStrobe, // synchronised strobe pin of port d
  output logic sharedClockInput // synchronised clock pin of port d
);
  import port_data_pkg::*;

  // two-stage synchroniser on all pins
  pin_bus_s pinMeta;
  pin_bus_s pinSync;
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pinMeta <= '0;
      pinSync <= '0;
    end else begin
      pinMeta <= pinIn;
      pinSync <= pinMeta;
    end
  end

  // per-port arrays, port d uses the low three bits
  logic [7:0] pinLvl [4];
  logic [7:0] oeTermV [4];
  logic [7:0] pldSelV [4];
  assign pinLvl[0] = pinSync.a;
  assign pinLvl[1] = pinSync.b;
  assign pinLvl[2] = pinSync.c;
  assign pinLvl[3] = {5'h00, pinSync.d};
  assign oeTermV[0] = oeTerm.a;
  assign oeTermV[1] = oeTerm.b;
  assign oeTermV[2] = oeTerm.c;
  assign oeTermV[3] = {5'h00, oeTerm.d};
  assign pldSelV[0] = pldPinSel.a;
  assign pldSelV[1] = pldPinSel.b;
  assign pldSelV[2] = pldPinSel.c;
  assign pldSelV[3] = 8'h00;

  // register space is disabled while the chip-select pin is high
  wire chipSelHigh = pinSync.d[PD_CHIP_SEL];
  assign memEnable = ~chipSelHigh; // R14
  wire regAccess = regReq.sel & ~chipSelHigh; // R14
  wire regWrite = regAccess & regReq.wr;
  wire regRead = regAccess & regReq.rd;
  wire [1:0] regPort = regReq.addr[4:3];
  wire [2:0] regKind = regReq.addr[2:0];

  // configuration registers
  logic [7:0] dataOut [4];
  logic [7:0] direction [4];
  logic [7:0] driveSel [4];
  logic [7:0] loadBlock [3];
  logic [7:0] imcStore [3];
  logic [7:0] drvMask [4];
  assign drvMask[0] = 8'hff;
  assign drvMask[1] = 8'hff;
  assign drvMask[2] = DRV_OPEN_DRAIN_MASK_C; // R11
  assign drvMask[3] = DRV_SLEW_MASK_D; // R13

  // output macrocells and their routing
  logic [7:0] groupAb;
  logic [7:0] groupBc;
  logic [7:0] omcPort [3];
  assign omcPort[0] = groupAbToB ? 8'h00 : groupAb; // R8
  assign omcPort[1] = groupAbToB ? groupAb : (groupBcToC ? 8'h00 : groupBc); // R8
  assign omcPort[2] = groupBcToC ? groupBc : 8'h00; // R8
  wire [1:0] abPort = groupAbToB ? PORT_B : PORT_A;
  wire [1:0] bcPort = groupBcToC ? PORT_C : PORT_B;
  // when both groups land on port b, group ab owns the port b location
  wire bcOnBShadowed = groupAbToB & ~groupBcToC;
  wire omcWrite = regWrite & (regKind == REG_OUTPUT_CELL_ACCESS);
  wire abWrite = omcWrite & (regPort == abPort);
  wire bcWrite = omcWrite & (regPort == bcPort) & ~bcOnBShadowed;
  wire [7:0] abBlock = loadBlock[abPort];
  wire [7:0] bcBlock = loadBlock[bcPort];
  wire [7:0] abLoad = {8{abWrite}} & ~abBlock; // R3 R4
  wire [7:0] bcLoad = {8{bcWrite}} & ~bcBlock; // R3 R4
  wire [7:0] next_groupAb = (abLoad & regReq.wdata) | (~abLoad & groupAbNext);
  wire [7:0] next_groupBc = (bcLoad & regReq.wdata) | (~bcLoad & groupBcNext);

  // macrocells run on the shared clock input, which is clk_sys here
  always_ff @(posedge clk_sys) begin // R17
    if (reset) begin
      groupAb <= RST_CELL;
      groupBc <= RST_CELL;
    end else begin
      groupAb <= next_groupAb;
      groupBc <= next_groupBc;
    end
  end

  // port a bus modes take the port over from the general i/o logic
  wire portABus = dataPortMode | periphMode; // R10

  // pin drive per port
  logic [7:0] outVal [4];
  logic [7:0] enVal [4];
  logic [7:0] padOe [4];
  logic [7:0] odSel [4];
  assign odSel[0] = driveSel[0] & DRV_OPEN_DRAIN_MASK_AB; // R9
  assign odSel[1] = driveSel[1] & DRV_OPEN_DRAIN_MASK_AB; // R9
  assign odSel[2] = driveSel[2] & DRV_OPEN_DRAIN_MASK_C; // R11
  assign odSel[3] = 8'h00;

  genvar p;
  generate
    for (p = 0; p < 3; p++) begin : g_io
      wire [7:0] ioOut = (pldSelV[p] & omcPort[p]) | (~pldSelV[p] & dataOut[p]);
      wire [7:0] ioEn = direction[p] | oeTermV[p]; // R1 R18
      if (p == 0) begin : g_a
        assign outVal[p] = portABus ? mcuDataOut : ioOut; // R10
        assign enVal[p] = portABus ? {8{mcuDataOe}} : ioEn; // R10
      end else begin : g_bc
        assign outVal[p] = ioOut;
        assign enVal[p] = ioEn;
      end
      // open drain only pulls low
      assign padOe[p] = enVal[p] & ~(odSel[p] & outVal[p]); // R9 R11
    end
  endgenerate

  // port d: external chip selects with polarity, driver by term or direction
  assign externalChipSelect = ecsTerm ^ ecsActiveLow; // R15
  wire [2:0] pdOut = (ecsPinSel & externalChipSelect) | (~ecsPinSel & dataOut[3][2:0]);
  assign outVal[3] = {5'h00, pdOut};
  assign enVal[3] = (direction[3] | oeTermV[3]) & PORT_D_MASK; // R16 R1
  assign padOe[3] = enVal[3];

  assign pinOut.a = outVal[0];
  assign pinOut.b = outVal[1];
  assign pinOut.c = outVal[2];
  assign pinOut.d = outVal[3][2:0];
  assign pinOe.a = padOe[0];
  assign pinOe.b = padOe[1];
  assign pinOe.c = padOe[2];
  assign pinOe.d = padOe[3][2:0];
  assign slewFast.a = driveSel[0] & DRV_SLEW_MASK_AB; // R9
  assign slewFast.b = driveSel[1] & DRV_SLEW_MASK_AB; // R9
  assign slewFast.c = 8'h00; // R11
  assign slewFast.d = driveSel[3][2:0];

  // port d inputs go straight to the array, no input macrocells
  assign portDDirect = pinSync.d; // R13
  assign addrLatchStrobe = pinSync.d[PD_STROBE];
  assign sharedClockInput = pinSync.d[PD_CLOCK];
  assign byteLaneEnable = byteLaneMode & pinSync.c[PC_BYTE_LANE]; // R12
  assign pldInputBus = {imcStore[2], imcStore[1], imcStore[0]}; // R6

  // writable registers, per port
  generate
    for (p = 0; p < 4; p++) begin : g_reg
      wire portHit = regWrite & (regPort == 2'(p));
      wire wrOut = portHit & (regKind == REG_PIN_OUTPUT_LATCH);
      wire wrDir = portHit & (regKind == REG_DIRECTION);
      wire wrDrv = portHit & (regKind == REG_DRIVE_SELECT);
      wire [7:0] wMask = (p == 3) ? PORT_D_MASK : 8'hff;
      always_ff @(posedge clk_sys) begin
        if (reset) begin
          dataOut[p] <= RST_OUTPUT_LATCH; // R20
          direction[p] <= RST_DIRECTION; // R18
          driveSel[p] <= RST_DRIVE;
        end else begin
          if (wrOut) dataOut[p] <= regReq.wdata & wMask; // R2
          if (wrDir) direction[p] <= regReq.wdata & wMask; // R18
          if (wrDrv) driveSel[p] <= regReq.wdata & drvMask[p];
        end
      end
      if (p < 3) begin : g_cell
        wire wrBlk = portHit & (regKind == REG_OUTPUT_CELL_LOAD_BLOCK);
        always_ff @(posedge clk_sys) begin
          if (reset) begin
            loadBlock[p] <= RST_LOAD_BLOCK; // R4
            imcStore[p] <= RST_CELL;
          end else begin
            if (wrBlk) loadBlock[p] <= regReq.wdata; // R4 R5
            if (imcCapture[p]) imcStore[p] <= pinLvl[p]; // R6
          end
        end
      end
    end
  endgenerate

  // read multiplexer; cell registers of port d are absent and read zero
  wire cellPort = (regPort != PORT_D); // R5
  logic [7:0] rdMux;
  always_comb begin
    rdMux = 8'h00;
    unique case (regKind)
      REG_PIN_INPUT_LEVELS: rdMux = pinLvl[regPort]; // R19
      REG_PIN_OUTPUT_LATCH: rdMux = dataOut[regPort]; // R2
      REG_DIRECTION: rdMux = direction[regPort];
      REG_DRIVE_SELECT: rdMux = driveSel[regPort];
      REG_OUTPUT_CELL_ACCESS: rdMux = cellPort ? omcPort[regPort] : 8'h00; // R3 R5
      REG_OUTPUT_CELL_LOAD_BLOCK: rdMux = cellPort ? loadBlock[regPort] : 8'h00; // R4 R5
      REG_INPUT_CELL_READBACK: rdMux = cellPort ? imcStore[regPort] : 8'h00; // R6 R5
      REG_DRIVER_ENABLE_STATUS: rdMux = cellPort ? enVal[regPort] : 8'h00; // R7 R5
    endcase
  end

  // read data holds until the next read
  always_ff @(posedge clk_sys) begin
    if (reset) regRdata <= 8'h00;
    else if (regRead) regRdata <= rdMux;
  end
endmodule

// *** sim/port_data_register_logic_assertions.sv ***
// checker: port-level timing and decode relations of the port data block
// assumes: bound to port_data_register_logic, one clock, synchronous reset
`timescale 1ns/1ps
module port_data_register_logic_assertions
  import port_data_pkg::*;
(
  input wire logic clk_sys, // clock
  input wire logic reset, // reset
  input port_data_pkg::reg_req_s regReq, // request
  input wire logic [7:0] regRdata, // read data
  input port_data_pkg::pin_bus_s pinIn, // pins in
  input port_data_pkg::pin_bus_s pinOe, // drivers
  input port_data_pkg::pin_bus_s slewFast, // slew
  input port_data_pkg::pin_bus_s oeTerm, // oe terms
  input wire logic [2:0] imcCapture, // capture
  input wire logic [23:0] pldInputBus, // input cells
  input wire logic mcuDataOe, // bus drive
  input wire logic [2:0] ecsTerm, // cs terms
  input wire logic [2:0] ecsActiveLow, // polarity
  input wire logic [2:0] externalChipSelect, // cs out
  input wire logic memEnable, // memories on
  input wire logic sharedClockInput // clock pin
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  // synchronisers restart at reset, so pin history is trusted only from the fourth edge
  logic [1:0] age;
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      age <= 2'h0;
    end else if (age != 2'h3) begin
      age <= age + 2'h1;
    end
  end
  chk_cs_polarity: assert property (externalChipSelect == (ecsTerm ^ ecsActiveLow))
    else $error("chip select polarity wrong");
  chk_clock_sync: assert property (age == 2'h3 |-> sharedClockInput == $past(pinIn.d[1], 2))
    else $error("clock pin not passed on");
  chk_mem_block: assert property (pinIn.d[2] [*3] |-> !memEnable)
    else $error("memories not blocked");
  chk_oe_term: assert property ((oeTerm.d & ~pinOe.d) == 3'h0)
    else $error("chip select driver off");
  chk_slew_legal: assert property (((slewFast.a | slewFast.b) & 8'hf0) == 8'h00
    && slewFast.c == 8'h00) else $error("slew on illegal pin");
  chk_reset_idle: assert property ($past(reset) && oeTerm == '0 && !mcuDataOe
    |-> pinOe == '0) else $error("driver on after reset");
  chk_rdata_hold: assert property (age != 2'h0 && !$past(regReq.sel && regReq.rd)
    |-> $stable(regRdata)) else $error("read data moved");
  chk_imc_store: assert property (age == 2'h3 && $past(imcCapture[0])
    |-> pldInputBus[7:0] == $past(pinIn.a, 3)) else $error("input cell wrong");
endmodule
bind port_data_register_logic port_data_register_logic_assertions chk (.clk_sys, .reset,
  .regReq, .regRdata, .pinIn, .pinOe, .slewFast, .oeTerm, .imcCapture, .pldInputBus,
  .mcuDataOe, .ecsTerm, .ecsActiveLow, .externalChipSelect, .memEnable, .sharedClockInput);

// *** sim/mcu_bus_model.sv ***
// bus model: 8-bit mcu issuing register reads and writes
// assumes: one request at a time; read data is valid the cycle after the strobe
`timescale 1ns/1ps
module mcu_bus_model
  import port_data_pkg::*;
(
  input wire logic clk_sys, // bus clock
  output port_data_pkg::reg_req_s regReq, // request
  input wire logic [7:0] regRdata // read data
);
  initial regReq = '0;
  // idle address and data are inverted so a stale value never looks fresh
  task xfer(input logic w, input logic [4:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk_sys);
    regReq <= '{1'b1, w, !w, a, d};
    @(posedge clk_sys);
    regReq <= '{1'b0, 1'b0, 1'b0, ~a, ~d};
    #1 q = regRdata;
  endtask
endmodule

// *** sim/tb_port_data_register_logic.sv ***
// testbench: port data block driven through the mcu bus model and its pins
// assumes: bus model and bound checker compiled before this file
`timescale 1ns/1ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin failures++; \
  $display("MISMATCH %s exp %h got %h", n, e, g); end end
module tb_port_data_register_logic;
  import port_data_pkg::*;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  reg_req_s regReq;
  logic [7:0] regRdata, q, groupAbNext = 8'h00, groupBcNext = 8'h00;
  pin_bus_s pinIn, pinOut, pinOe, slewFast, extPin = '0, oeTerm = '0, pldPinSel = '0;
  logic groupAbToB = 1'b0, groupBcToC = 1'b0, byteLaneMode = 1'b0;
  logic byteLaneEnable, memEnable, addrLatchStrobe, sharedClockInput;
  logic [2:0] imcCapture = 3'h0, ecsTerm = 3'h0, ecsActiveLow = 3'h0;
  logic [2:0] externalChipSelect, portDDirect;
  logic dataPortMode = 1'b0, periphMode = 1'b0, mcuDataOe = 1'b0;
  logic [7:0] mcuDataOut = 8'h00;
  logic [23:0] pldInputBus;
  int failures = 0;
  int compares = 0;
  always #25 clk_sys = ~clk_sys;
  // wire level: our driver where enabled, otherwise the outside world
  assign pinIn = pin_bus_s'((pinOut & pinOe) | (extPin & ~pinOe));
  mcu_bus_model m (.clk_sys, .regReq, .regRdata);
  port_data_register_logic uut (.clk_sys, .reset, .regReq, .regRdata, .pinIn, .pinOut, .pinOe,
    .slewFast, .oeTerm, .pldPinSel, .groupAbNext, .groupBcNext, .groupAbToB, .groupBcToC,
    .imcCapture, .pldInputBus, .portDDirect, .dataPortMode, .periphMode,
    .mcuDataOut, .mcuDataOe, .byteLaneMode, .byteLaneEnable, .ecsTerm,
    .ecsActiveLow, .ecsPinSel(3'h7), .externalChipSelect, .memEnable, .addrLatchStrobe,
    .sharedClockInput);
  task test_done;
    if (failures == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task wr(input logic [1:0] p, input logic [2:0] k, input logic [7:0] d);
    m.xfer(1'b1, {p, k}, d, q);
  endtask
  task rd(input logic [1:0] p, input logic [2:0] k, input logic [7:0] e);
    m.xfer(1'b0, {p, k}, 8'h00, q);
    `CHK("regRdata", e, q)
  endtask
  task t_reset;
    rd(PORT_A, REG_PIN_OUTPUT_LATCH, 8'h00);
    rd(PORT_B, REG_OUTPUT_CELL_LOAD_BLOCK, 8'h00);
    rd(PORT_C, REG_DRIVER_ENABLE_STATUS, 8'h00);
    `CHK("pinOe", 27'h0, pinOe)
  endtask
  task t_latch;
    wr(PORT_A, REG_PIN_OUTPUT_LATCH, 8'ha5);
    wr(PORT_A, REG_DIRECTION, 8'h0f);
    `CHK("pinOe.a", 8'h0f, pinOe.a)
    `CHK("pinOut.a", 8'ha5, pinOut.a)
    @(posedge clk_sys);
    oeTerm.a <= 8'h30;
    @(posedge clk_sys);
    #1;
    `CHK("pinOe.a", 8'h3f, pinOe.a)
    rd(PORT_A, REG_PIN_OUTPUT_LATCH, 8'ha5);
    rd(PORT_A, REG_DRIVER_ENABLE_STATUS, 8'h3f);
  endtask
  task t_drive;
    wr(PORT_A, REG_DRIVE_SELECT, 8'hff);
    wr(PORT_C, REG_DIRECTION, 8'hff);
    wr(PORT_C, REG_PIN_OUTPUT_LATCH, 8'h8f);
    wr(PORT_C, REG_DRIVE_SELECT, 8'hff);
    `CHK("slewFast.a", 8'h0f, slewFast.a)
    `CHK("slewFast.c", 8'h00, slewFast.c)
    `CHK("pinOe.a", 8'h1f, pinOe.a)
    `CHK("pinOe.c", 8'h70, pinOe.c)
  endtask
  task t_pins;
    @(posedge clk_sys);
    extPin.b <= 8'h3c;
    extPin.d <= 3'h3;
    repeat (2) @(posedge clk_sys);
    rd(PORT_B, REG_PIN_INPUT_LEVELS, 8'h3c);
    rd(PORT_D, REG_OUTPUT_CELL_ACCESS, 8'h00);
    `CHK("portDDirect", 3'h3, portDDirect)
    `CHK("addrLatchStrobe", 1'b1, addrLatchStrobe)
    `CHK("sharedClockInput", 1'b1, sharedClockInput)
  endtask
  task t_cells;
    @(posedge clk_sys);
    groupAbNext <= 8'h5a;
    groupBcNext <= 8'h33;
    pldPinSel <= '1;
    wr(PORT_A, REG_OUTPUT_CELL_LOAD_BLOCK, 8'h0f);
    rd(PORT_A, REG_OUTPUT_CELL_LOAD_BLOCK, 8'h0f);
    wr(PORT_A, REG_OUTPUT_CELL_ACCESS, 8'hff);
    `CHK("pinOut.a", 8'hfa, pinOut.a)
    rd(PORT_A, REG_OUTPUT_CELL_ACCESS, 8'h5a);
    @(posedge clk_sys);
    groupAbToB <= 1'b1;
    groupBcToC <= 1'b1;
    repeat (2) @(posedge clk_sys);
    #1;
    `CHK("pinOut.b", 8'h5a, pinOut.b)
    `CHK("pinOut.c", 8'h33, pinOut.c)
  endtask
  task t_inputs;
    // pc7 is still driven low by the open-drain output, pldPinSel putting group bc (8'h33, bit 7 being 0) on the pin; it is turned back into an input
    wr(PORT_C, REG_DIRECTION, 8'h7f);
    @(posedge clk_sys);
    extPin.c <= 8'h80;
    byteLaneMode <= 1'b1;
    imcCapture <= 3'h3;
    @(posedge clk_sys);
    imcCapture <= 3'h0;
    extPin.b <= 8'h00;
    repeat (2) @(posedge clk_sys);
    rd(PORT_B, REG_INPUT_CELL_READBACK, 8'h3c);
    `CHK("pldInputBus.b", 8'h3c, pldInputBus[15:8])
    `CHK("byteLaneEnable", 1'b1, byteLaneEnable)
  endtask
  task t_select;
    wr(PORT_B, REG_PIN_OUTPUT_LATCH, 8'h11);
    @(posedge clk_sys);
    extPin.d <= 3'h4;
    repeat (3) @(posedge clk_sys);
    #1;
    `CHK("memEnable", 1'b0, memEnable)
    wr(PORT_B, REG_PIN_OUTPUT_LATCH, 8'h77);
    @(posedge clk_sys);
    extPin.d <= 3'h0;
    repeat (3) @(posedge clk_sys);
    rd(PORT_B, REG_PIN_OUTPUT_LATCH, 8'h11);
  endtask
  task t_chip;
    @(posedge clk_sys);
    ecsTerm <= 3'h5;
    ecsActiveLow <= 3'h3;
    oeTerm.d <= 3'h1;
    wr(PORT_D, REG_DIRECTION, 8'h02);
    `CHK("externalChipSelect", 3'h6, externalChipSelect)
    `CHK("pinOe.d", 3'h3, pinOe.d)
    `CHK("pinOut.d", 3'h6, pinOut.d)
    wr(PORT_D, REG_DRIVE_SELECT, 8'hff);
    `CHK("slewFast.d", 3'h7, slewFast.d)
  endtask
  task t_bus;
    @(posedge clk_sys);
    dataPortMode <= 1'b1;
    mcuDataOut <= 8'hc3;
    mcuDataOe <= 1'b1;
    @(posedge clk_sys);
    #1;
    `CHK("pinOut.a", 8'hc3, pinOut.a)
    rd(PORT_A, REG_DRIVER_ENABLE_STATUS, 8'hff);
    @(posedge clk_sys);
    dataPortMode <= 1'b0;
    periphMode <= 1'b1;
    mcuDataOe <= 1'b0;
    @(posedge clk_sys);
    #1;
    `CHK("pinOe.a", 8'h00, pinOe.a)
    @(posedge clk_sys);
    periphMode <= 1'b0;
  endtask
  initial begin
    repeat (4) @(posedge clk_sys);
    reset <= 1'b0;
    t_reset();
    t_latch();
    t_drive();
    t_pins();
    t_cells();
    t_inputs();
    t_select();
    t_chip();
    t_bus();
    test_done();
  end
  initial begin
    repeat (4000) @(posedge clk_sys);
    failures++;
    test_done();
  end
endmodule
